/* File: srs_pkg.sv */
// Shared constants for the receive reset sequencer.
// Assumes one 50 MHz clock and a word-wide AHB-Lite register port.
package srs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 50;
  localparam int UNIT_NS      = 80;  // One duration step
  localparam int UNIT_CYC     = (UNIT_NS * CLK_MHZ + 999) / 1000;
  localparam int UNIT_W       = 4;
  localparam int DUR_W        = 7;
  localparam int SHORT_W      = 5;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DUR0 = 8'h04;
  localparam logic [7:0] A_DUR1 = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam int ADDR_W       = 8;
  localparam int MODE_BIT     = 0;   // CTRL: 1 = single mode
  localparam int F_ANA        = 0;   // DUR0 fields
  localparam int F_PHS        = 8;
  localparam int F_FRQ        = 16;
  localparam int F_SCN        = 24;
  localparam int F_EQ         = 0;   // DUR1 fields
  localparam int F_PCS        = 8;
  localparam int F_BUF        = 16;
  localparam int F_OCT        = 24;
  localparam int S_CMP        = 0;   // STATUS fields
  localparam int S_ACMP       = 1;
  localparam int S_BUSY       = 2;
  localparam int S_IN_LSB     = 8;
  localparam int S_RG_LSB     = 16;
  localparam logic        RST_MODE = 1'b0;
  localparam logic [4:0]  RST_DUR5 = 5'h04;
  localparam logic [6:0]  RST_DUR7 = 7'h10;
  localparam logic [4:0]  RST_OCT  = 5'h00;
  localparam int HTRANS_ACT   = 1;

  // ----------------------------------------
  // Request inputs and reset regions
  // ----------------------------------------
  localparam int IN_FULL = 0, IN_ANA = 1, IN_EQ = 2, IN_SCN = 3;
  localparam int IN_PCS  = 4, IN_BUF = 5, IN_OOB = 6, IN_RDY = 7;
  localparam int NUM_IN  = 8;
  localparam int NUM_PEND = 5;       // Pending: analog, eq, scan, pcs, buf
  localparam int RG_ANA = 0, RG_PHS = 1, RG_FRQ = 2, RG_EQ = 3;
  localparam int RG_SCN = 4, RG_PCS = 5, RG_BUF = 6;
  localparam int NUM_RG = 7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_HOLD, ST_ANA, ST_PHS, ST_FRQ, ST_EQ, ST_SCN, ST_RDY, ST_PCS, ST_BUF
  } srs_state_t;
endpackage

/* File: srs_sync.sv */
// Two-flop synchroniser with release detection for a group of levels.
// Assumes inputs may change at any time relative to hclk.
`timescale 1ns/10ps
module srs_sync #(
  parameter int W = 8
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] prev_reg;

  // ----------------------------------------
  // Per-bit capture
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // Meta flop feeds only the second flop
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_reg[i] <= 1'b0;
          level[i]    <= 1'b0;
          prev_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= async_in[i];
          level[i]    <= meta_reg[i];
          prev_reg[i] <= level[i];
        end
      end
      // Release of a high level
      assign fall[i] = prev_reg[i] & ~level[i];
    end
  endgenerate
endmodule

/* File: srs_stage_timer.sv */
// Stage duration timer: counts a programmed number of duration steps.
// Assumes start is a one-cycle pulse; a new start restarts the count.
`timescale 1ns/10ps
module srs_stage_timer
  import srs_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             start,
  input  wire logic [DUR_W-1:0] len,
  output logic                  done
);
  logic [UNIT_W-1:0] div_reg;
  logic [DUR_W-1:0]  left_reg;
  logic              run_reg;
  logic              tick;

  // ----------------------------------------
  // Step divider
  // ----------------------------------------
  assign tick = run_reg && (div_reg == UNIT_W'(UNIT_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= '0;
    end else if (start || tick) begin
      div_reg <= '0;
    end else if (run_reg) begin
      div_reg <= div_reg + UNIT_W'(1);
    end
  end

  // ----------------------------------------
  // Step counter, zero length acts as one step
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      left_reg <= '0;
      run_reg  <= 1'b0;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        left_reg <= (len == '0) ? DUR_W'(1) : len;
        run_reg  <= 1'b1;
      end else if (tick) begin
        left_reg <= left_reg - DUR_W'(1);
        if (left_reg <= DUR_W'(1)) begin
          run_reg <= 1'b0;
          done    <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: srs_rx_reset_seq.sv */
// Receive reset sequencer of a serial transceiver channel.
// Assumes request inputs are asynchronous levels and software uses AHB-Lite words.
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps

// Notes on behaviour
// - Full reset release starts whole chain
// - Single analog reset touches analog only
// - Sequential analog reset runs full chain
// - Single equalizer reset touches equalizer only
// - Sequential equalizer reset chains to buffer
// - Single scan reset touches scan only
// - Sequential scan reset chains to buffer
// - Single coding reset touches coding only
// - Sequential coding reset then buffer
// - Coding stage waits for user ready
// - Buffer reset touches buffer only
// - Complete drops on full, needs ready
// - Single: complete after all released, ready
// - Analog complete drops on full/analog
// - Out-of-band reset independent of sequencer
// - No automatic start after configuration
module srs_rx_reset_seq
  import srs_pkg::*;
(
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [31:0]        hrdata,
  input  wire logic               rx_full_reset,
  input  wire logic               rx_analog_section_reset,
  input  wire logic               rx_equalizer_reset,
  input  wire logic               rx_margin_scan_reset,
  input  wire logic               rx_coding_sublayer_reset,
  input  wire logic               rx_elastic_buffer_reset,
  input  wire logic               rx_out_of_band_reset,
  input  wire logic               rx_user_side_ready,
  output logic      [NUM_RG-1:0]  region_reset,
  output logic                    oob_region_reset,
  output logic                    rx_reset_complete,
  output logic                    rx_analog_reset_complete
);
  logic [NUM_IN-1:0]   raw;
  logic [NUM_IN-1:0]   lvl;
  logic [NUM_IN-1:0]   fall;
  logic [NUM_PEND-1:0] pend_reg;
  logic [NUM_PEND-1:0] take;
  srs_state_t          state_reg;
  srs_state_t          state_next;
  logic                chain_reg;
  logic                chain_next;
  logic                ran_reg;
  logic                tstart;
  logic                tdone;
  logic [DUR_W-1:0]    tlen;
  logic                mode_single_reg;
  logic [31:0]         dur0_reg;
  logic [31:0]         dur1_reg;
  logic                wr_pend_reg;
  logic                rd_pend_reg;
  logic [ADDR_W-1:0]   addr_reg;
  logic                any_req;
  logic                addr_ok;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Register select for an aligned word address
  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      A_CTRL:  reg_sel = 2'h0;
      A_DUR0:  reg_sel = 2'h1;
      A_DUR1:  reg_sel = 2'h2;
      default: reg_sel = 2'h3;
    endcase
  endfunction

  // Next stage of a chain, or idle
  function automatic srs_state_t after(input srs_state_t s, input logic chain);
    after = ST_IDLE;
    if (chain) begin
      case (s)
        ST_ANA:  after = ST_PHS;
        ST_PHS:  after = ST_FRQ;
        ST_FRQ:  after = ST_EQ;
        ST_EQ:   after = ST_SCN;
        ST_SCN:  after = ST_PCS;
        ST_PCS:  after = ST_BUF;
        default: after = ST_IDLE;
      endcase
    end
  endfunction

  // Regions held in reset by a state
  function automatic logic [NUM_RG-1:0] region_of(input srs_state_t s);
    region_of = '0;
    case (s)
      ST_HOLD: region_of = '1;
      ST_ANA:  region_of[RG_ANA] = 1'b1;
      ST_PHS:  region_of[RG_PHS] = 1'b1;
      ST_FRQ:  region_of[RG_FRQ] = 1'b1;
      ST_EQ:   region_of[RG_EQ] = 1'b1;
      ST_SCN:  region_of[RG_SCN] = 1'b1;
      ST_PCS:  region_of[RG_PCS] = 1'b1;
      ST_BUF:  region_of[RG_BUF] = 1'b1;
      default: region_of = '0;
    endcase
  endfunction

  // Programmed duration of a timed stage
  function automatic logic [DUR_W-1:0] len_of(input srs_state_t s);
    case (s)
      ST_ANA:  len_of = DUR_W'(dur0_reg[F_ANA +: SHORT_W]);
      ST_PHS:  len_of = DUR_W'(dur0_reg[F_PHS +: SHORT_W]);
      ST_FRQ:  len_of = DUR_W'(dur0_reg[F_FRQ +: SHORT_W]);
      ST_EQ:   len_of = dur1_reg[F_EQ +: DUR_W];
      ST_SCN:  len_of = DUR_W'(dur0_reg[F_SCN +: SHORT_W]);
      ST_PCS:  len_of = DUR_W'(dur1_reg[F_PCS +: SHORT_W]);
      ST_BUF:  len_of = DUR_W'(dur1_reg[F_BUF +: SHORT_W]);
      default: len_of = '0;
    endcase
  endfunction

  // ----------------------------------------
  // Request synchronisation
  // ----------------------------------------
  assign raw[IN_FULL] = rx_full_reset;
  assign raw[IN_ANA]  = rx_analog_section_reset;
  assign raw[IN_EQ]   = rx_equalizer_reset;
  assign raw[IN_SCN]  = rx_margin_scan_reset;
  assign raw[IN_PCS]  = rx_coding_sublayer_reset;
  assign raw[IN_BUF]  = rx_elastic_buffer_reset;
  assign raw[IN_OOB]  = rx_out_of_band_reset;
  assign raw[IN_RDY]  = rx_user_side_ready;

  srs_sync #(
    .W        (NUM_IN)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (raw),
    .level    (lvl),
    .fall     (fall)
  );

  // Any sequencer request held high (out-of-band excluded)
  assign any_req = |lvl[IN_BUF:IN_FULL];

  // ----------------------------------------
  // Pending component requests
  // ----------------------------------------
  // A release landing with its take is kept
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_reg <= '0;
    end else begin
      pend_reg <= (pend_reg & ~take) | fall[IN_BUF:IN_ANA];
    end
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    chain_next = chain_reg;
    take       = '0;
    if (lvl[IN_FULL]) begin
      state_next = ST_HOLD;
      chain_next = 1'b1;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          state_next = ST_ANA;
        end
        ST_IDLE: begin
          chain_next = !mode_single_reg;
          if (pend_reg[0]) begin
            state_next = ST_ANA;
            take[0]    = 1'b1;
          end else if (pend_reg[1]) begin
            state_next = ST_EQ;
            take[1]    = 1'b1;
          end else if (pend_reg[2]) begin
            state_next = ST_SCN;
            take[2]    = 1'b1;
          end else if (pend_reg[3]) begin
            state_next = ST_PCS;
            take[3]    = 1'b1;
          end else if (pend_reg[4]) begin
            state_next = ST_BUF;
            take[4]    = 1'b1;
          end
        end
        ST_RDY: begin
          if (lvl[IN_RDY]) begin
            state_next = ST_PCS;
          end
        end
        default: begin
          if (tdone) begin
            state_next = after(state_reg, chain_reg);
          end
        end
      endcase
      if (state_next == ST_PCS && !lvl[IN_RDY]) begin
        state_next = ST_RDY;
      end
    end
  end

  // Timer restarts on every timed stage entry
  assign tstart = (state_next != state_reg) && !(state_next inside {ST_IDLE, ST_HOLD, ST_RDY});
  assign tlen   = len_of(state_next);

  srs_stage_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (tstart),
    .len     (tlen),
    .done    (tdone)
  );

  // ----------------------------------------
  // Sequencer state and region outputs
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg    <= ST_IDLE;
      chain_reg    <= 1'b0;
      region_reset <= '0;
    end else begin
      state_reg    <= state_next;
      chain_reg    <= chain_next;
      region_reset <= region_of(state_next);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oob_region_reset <= 1'b0;
    end else begin
      oob_region_reset <= lvl[IN_OOB];
    end
  end

  // ----------------------------------------
  // Completion flags
  // ----------------------------------------
  // no completion before a first run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ran_reg <= 1'b0;
    end else if (state_reg != ST_IDLE && state_next == ST_IDLE) begin
      ran_reg <= 1'b1;
    end
  end

  // drop on full, rise with ready
  // wait for all releases and ready
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_reset_complete <= 1'b0;
    end else if (any_req || state_reg != ST_IDLE || pend_reg != '0 || fall[IN_BUF:IN_ANA] != '0) begin
      rx_reset_complete <= 1'b0;
    end else if (ran_reg && lvl[IN_RDY]) begin
      rx_reset_complete <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_analog_reset_complete <= 1'b0;
    end else if (lvl[IN_FULL] || lvl[IN_ANA] || state_reg == ST_HOLD) begin
      rx_analog_reset_complete <= 1'b0;
    end else if (state_reg == ST_ANA && tdone) begin
      rx_analog_reset_complete <= 1'b1;
    end
  end

  // ----------------------------------------
  // AHB-Lite slave
  // ----------------------------------------
  assign addr_ok = hsel && hready && htrans[HTRANS_ACT];

  // Address phase capture; reads take one wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= '0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      hreadyout   <= !(addr_ok && !hwrite);
      if (addr_ok) begin
        addr_reg <= haddr[ADDR_W-1:0];
      end
    end
  end

  // Writable control and duration words
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_single_reg <= RST_MODE;
      dur0_reg        <= {3'h0, RST_DUR5, 3'h0, RST_DUR5, 3'h0, RST_DUR5, 3'h0, RST_DUR5};
      dur1_reg        <= {3'h0, RST_OCT, 3'h0, RST_DUR5, 3'h0, RST_DUR5, 1'h0, RST_DUR7};
    end else if (wr_pend_reg) begin
      case (reg_sel(addr_reg))
        2'h0:    mode_single_reg <= hwdata[MODE_BIT];
        2'h1:    dur0_reg <= hwdata & 32'h1f1f1f1f;
        2'h2:    dur1_reg <= hwdata & 32'h1f1f1f7f;
        default: mode_single_reg <= mode_single_reg;
      endcase
    end
  end

  // Read data loaded in the wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_pend_reg) begin
      hrdata <= '0;
      case (reg_sel(addr_reg))
        2'h0:    hrdata[MODE_BIT] <= mode_single_reg;
        2'h1:    hrdata <= dur0_reg;
        2'h2:    hrdata <= dur1_reg;
        default: begin
          if (addr_reg == A_STAT) begin
            hrdata[S_CMP]                    <= rx_reset_complete;
            hrdata[S_ACMP]                   <= rx_analog_reset_complete;
            hrdata[S_BUSY]                   <= (state_reg != ST_IDLE);
            hrdata[S_IN_LSB +: NUM_IN]       <= lvl;
            hrdata[S_RG_LSB +: NUM_RG]       <= region_reset;
          end
        end
      endcase
    end
  end
endmodule

/* File: srs_monitor.sv */
// Port checker for the receive reset sequencer.
// Assumes it is bound to srs_rx_reset_seq and sees only its ports.
`timescale 1ns/10ps
module srs_monitor
  import srs_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              rx_full_reset,
  input wire logic              rx_analog_section_reset,
  input wire logic              rx_equalizer_reset,
  input wire logic              rx_margin_scan_reset,
  input wire logic              rx_coding_sublayer_reset,
  input wire logic              rx_elastic_buffer_reset,
  input wire logic              rx_out_of_band_reset,
  input wire logic              rx_user_side_ready,
  input wire logic [NUM_RG-1:0] region_reset,
  input wire logic              oob_region_reset,
  input wire logic              rx_reset_complete,
  input wire logic              rx_analog_reset_complete
);
  logic others;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Any sequencer request line high
  assign others = rx_full_reset | rx_analog_section_reset | rx_equalizer_reset
                | rx_margin_scan_reset | rx_coding_sublayer_reset | rx_elastic_buffer_reset;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Completion and region behaviour
  full_done_a : assert property (rx_full_reset [*4] |=> !rx_reset_complete)
    else $error("Complete stayed high under full reset");
  full_regions_a : assert property (rx_full_reset [*5] |=> region_reset == {NUM_RG{1'b1}})
    else $error("Regions not all held under full reset");
  ana_done_a : assert property ((rx_full_reset || rx_analog_section_reset) [*4] |=> !rx_analog_reset_complete)
    else $error("Analog complete stayed high");
  coding_ready_a : assert property ($rose(region_reset[RG_PCS]) && !region_reset[RG_ANA] |-> $past(rx_user_side_ready, 3))
    else $error("Coding stage began without ready");
  done_ready_a : assert property ($rose(rx_reset_complete) |-> $past(rx_user_side_ready, 3))
    else $error("Complete rose without ready");
  done_clear_a : assert property ($rose(rx_reset_complete) |-> region_reset == '0)
    else $error("Complete rose with a region in reset");
  oob_copy_a : assert property (oob_region_reset == $past(rx_out_of_band_reset, 3))
    else $error("Out-of-band region reset not a delayed copy");
  oob_quiet_a : assert property ((rx_out_of_band_reset && !others) [*4] ##0 rx_reset_complete |=> rx_reset_complete)
    else $error("Out-of-band reset moved complete");
  phase_order_a : assert property ($rose(region_reset[RG_PHS]) && !region_reset[RG_ANA] |-> $past(region_reset[RG_ANA]))
    else $error("Phase stage not after analog stage");

  // Main scenarios reached
  cover property ($rose(rx_reset_complete));
  cover property ($rose(region_reset[RG_PCS]));
  cover property (rx_out_of_band_reset && rx_reset_complete);
endmodule

bind srs_rx_reset_seq srs_monitor u_mon (.hclk, .hresetn, .rx_full_reset, .rx_analog_section_reset,
  .rx_equalizer_reset, .rx_margin_scan_reset, .rx_coding_sublayer_reset, .rx_elastic_buffer_reset,
  .rx_out_of_band_reset, .rx_user_side_ready, .region_reset, .oob_region_reset, .rx_reset_complete,
  .rx_analog_reset_complete);

/* File: srs_user_model.sv */
// User fabric model: request pulses and the ready level.
// Assumes the bench commands one request at a time.
`timescale 1ns/10ps
module srs_user_model
  import srs_pkg::*;
#(
  parameter int HOLD_CYC = 6
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              go,
  input  wire logic [2:0]        kind,
  input  wire logic              rdy_en,
  output logic      [NUM_IN-1:0] lines
);
  logic [NUM_IN-2:0] pulse_reg;
  int                cnt_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_reg <= '0;
      cnt_reg   <= 0;
    end else if (go && cnt_reg == 0) begin
      pulse_reg       <= '0;
      pulse_reg[kind] <= 1'b1;
      cnt_reg         <= HOLD_CYC;
    end else if (cnt_reg > 1) begin
      cnt_reg <= cnt_reg - 1;
    end else begin
      pulse_reg <= '0;
      cnt_reg   <= 0;
    end
  end

  assign lines = {rdy_en, pulse_reg};
endmodule

/* File: srs_tb.sv */
// Self-checking bench for the receive reset sequencer.
// Assumes a 50 MHz clock, AHB-Lite registers and the user model.
`timescale 1ns/10ps
module tb;
  import srs_pkg::*;
  logic              hclk, hresetn, hsel, hwrite, go, rdy_en, hreadyout, hresp;
  logic              oob_region_reset, rx_reset_complete, rx_analog_reset_complete;
  logic [31:0]       haddr, hwdata, hrdata, rd, log_q, e;
  logic [1:0]        htrans;
  logic [2:0]        hsize, kind;
  logic [NUM_IN-1:0] lines;
  logic [NUM_RG-1:0] region_reset, prev_q;
  int                mismatches, tests_run, st, lows, seen_oob;
  localparam logic [7:0]  RA [5] = '{A_CTRL, A_DUR0, A_DUR1, A_STAT, 8'h10};
  localparam logic [31:0] RM [5] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'h007f0007, 32'hffffffff};
  localparam logic [31:0] RE [5] = '{32'h0, 32'h04040404, 32'h00040410, 32'h0, 32'h0};

  srs_rx_reset_seq DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_full_reset(lines[IN_FULL]),
    .rx_analog_section_reset(lines[IN_ANA]), .rx_equalizer_reset(lines[IN_EQ]),
    .rx_margin_scan_reset(lines[IN_SCN]), .rx_coding_sublayer_reset(lines[IN_PCS]),
    .rx_elastic_buffer_reset(lines[IN_BUF]), .rx_out_of_band_reset(lines[IN_OOB]),
    .rx_user_side_ready(lines[IN_RDY]), .region_reset, .oob_region_reset, .rx_reset_complete,
    .rx_analog_reset_complete);
  srs_user_model u_user (.hclk, .hresetn, .go, .kind, .rdy_en, .lines);

  // ----------------------------------------
  // Clock and stage logger
  // ----------------------------------------
  // Free-running 50 MHz clock
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // Records each region start, one nibble of region index plus one
  always @(posedge hclk) begin
    for (int i = 0; i < NUM_RG; i++) begin
      if (region_reset[i] === 1'b1 && prev_q[i] !== 1'b1) log_q = (log_q << 4) | 32'(i + 1);
    end
    prev_q = region_reset;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Wait on hreadyout or on complete, bounded
  task automatic wait_on(input bit bus);
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while ((bus ? hreadyout : rx_reset_complete) !== 1'b1 && k < 800);
    if (k >= 800) begin
      mismatches++;
      $display("BAD %0t: wait ran out", $time);
      results();
    end
  endtask

  // One AHB-Lite single word transfer
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_on(1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_on(1'b1);
    rd = hrdata;
  endtask

  // Pulse one request line, check completion drops
  task automatic fire(input logic [2:0] k);
    @(negedge hclk);
    log_q = 32'h0;
    @(posedge hclk);
    go   <= 1'b1;
    kind <= k;
    @(posedge hclk);
    go <= 1'b0;
    repeat (6) @(negedge hclk);
    chk(rx_reset_complete, 32'h0);
    if (k == IN_ANA || k == IN_FULL) chk(rx_analog_reset_complete, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    go = 1'b0;
    kind = 3'h0;
    rdy_en = 1'b0;
    log_q = 32'h0;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (50) @(posedge hclk);
    chk({rx_reset_complete, region_reset}, 32'h0);
    for (int i = 0; i < 5; i++) begin
      ahb(1'b0, RA[i], 32'h0);
      chk(rd & RM[i], RE[i]);
    end
    ahb(1'b1, A_DUR0, 32'h01010101);
    ahb(1'b1, A_DUR1, 32'h00010101);
    ahb(1'b0, A_DUR1, 32'h0);
    chk(rd, 32'h00010101);
    $display("test registers done");
    rdy_en <= 1'b1;
    fire(IN_FULL);
    wait_on(1'b0);
    chk({rx_analog_reset_complete, region_reset}, 32'h80);
    chk(log_q, 32'h67234567);
    $display("test full reset done");
    for (int m = 0; m < 2; m++) begin
      ahb(1'b1, A_CTRL, 32'(m));
      for (int k = IN_ANA; k <= IN_BUF; k++) begin
        st = (k == IN_ANA) ? 0 : k + 1;
        e = 32'(st + 1);
        for (int r = st + 1; r < NUM_RG && m == 0; r++) e = (e << 4) | 32'(r + 1);
        fire(3'(k));
        wait_on(1'b0);
        chk(log_q, e);
      end
      $display("test mode %0d done", m);
    end
    ahb(1'b1, A_CTRL, 32'h0);
    // back to sequential, wait 400 ns
    repeat (20) @(posedge hclk);
    fire(IN_FULL);
    wait_on(1'b0);
    chk(log_q, 32'h67234567);
    $display("test mode switch done");
    rdy_en <= 1'b0;
    fire(IN_PCS);
    repeat (60) @(posedge hclk);
    chk(log_q, 32'h0);
    chk(rx_reset_complete, 32'h0);
    rdy_en <= 1'b1;
    wait_on(1'b0);
    chk(log_q, 32'h67);
    $display("test ready gate done");
    lows = 0;
    seen_oob = 0;
    go   <= 1'b1;
    kind <= 3'(IN_OOB);
    @(posedge hclk);
    go <= 1'b0;
    repeat (14) begin
      @(negedge hclk);
      if (rx_reset_complete !== 1'b1) lows++;
      if (oob_region_reset === 1'b1) seen_oob++;
    end
    chk(lows, 32'h0);
    chk(seen_oob, 32'h6);
    ahb(1'b1, 8'h10, 32'hffffffff);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, A_STAT, 32'h0);
    chk(rd & 32'h3, 32'h3);
    $display("test out-of-band and map done");
    results();
  end
endmodule
